// ==== hw/exc_entry_pkg.sv ====
package exc_entry_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;

    // ==========================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_STATE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SAVE_PC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SAVE_STATE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CRIT_PC = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CRIT_STATE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SYNDROME = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_FAULT_ADDR = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_COUNTER = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_TSTATUS = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_TCONTROL = 8'h28;

    // ==========================================
    // machine_state_word bit positions
    localparam int unsigned MS_AUX_EN = 25;
    localparam int unsigned MS_AUX_EXC = 19;
    localparam int unsigned MS_WAIT = 18;
    localparam int unsigned MS_CRIT_EN = 17;
    localparam int unsigned MS_EXT_EN = 15;
    localparam int unsigned MS_USER = 14;
    localparam int unsigned MS_FLOAT_EN = 13;
    localparam int unsigned MS_MCHK_EN = 12;
    localparam int unsigned MS_FLT_MODE0 = 11;
    localparam int unsigned MS_DBG_WAIT = 10;
    localparam int unsigned MS_DBG_EN = 9;
    localparam int unsigned MS_FLT_MODE1 = 8;
    localparam int unsigned MS_INSTR_RELOC = 5;
    localparam int unsigned MS_DATA_RELOC = 4;

    localparam logic [DATA_W-1:0] ENTRY_CLEAR_MASK =
        (32'h1 << MS_AUX_EN) | (32'h1 << MS_AUX_EXC) |
        (32'h1 << MS_WAIT) | (32'h1 << MS_EXT_EN) |
        (32'h1 << MS_USER) | (32'h1 << MS_FLOAT_EN) |
        (32'h1 << MS_FLT_MODE0) | (32'h1 << MS_DBG_WAIT) |
        (32'h1 << MS_FLT_MODE1) | (32'h1 << MS_INSTR_RELOC) |
        (32'h1 << MS_DATA_RELOC);

    // ==========================================
    // timer fields
    localparam int unsigned TS_TIMEOUT = 0;
    localparam int unsigned TC_IRQ_EN = 0;
    localparam int unsigned TC_AUTO_RELOAD = 1;

    // ==========================================
    // reset values and vectors
    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] VEC_FLOAT = 32'h0000_0800;
    localparam logic [DATA_W-1:0] VEC_SYSCALL = 32'h0000_0C00;
    localparam logic [DATA_W-1:0] VEC_AUX = 32'h0000_0F20;
    localparam logic [DATA_W-1:0] VEC_INTERVAL = 32'h0000_1000;
    localparam logic [DATA_W-1:0] INSTR_BYTES = 32'h0000_0004;
    localparam logic [DATA_W-1:0] COUNT_ONE = 32'h0000_0001;

    // ==========================================
    // instruction stream
    typedef enum logic [2:0] {
        KIND_PLAIN = 3'b000,
        KIND_FLOAT = 3'b001,
        KIND_AUX = 3'b010,
        KIND_SYSCALL = 3'b011,
        KIND_RETURN = 3'b100
    } instr_kind_e;

    typedef struct packed {
        logic valid;
        instr_kind_e kind;
        logic [DATA_W-1:0] pc;
    } instr_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] pc;
    } redirect_s;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_FLOAT = 3'b001,
        CAUSE_AUX = 3'b010,
        CAUSE_SYSCALL = 3'b011,
        CAUSE_INTERVAL = 3'b100,
        CAUSE_RETURN = 3'b101
    } cause_e;

endpackage : exc_entry_pkg

// ==== hw/cpu_exception_entry_unit.sv ====
// What this block does
// - disabled float instruction vectors to 0x0800
// - no float unit: float exception never raised
// - float/aux fault saves faulting instruction address
// - system call vectors to 0x0C00 unless a timer interrupt is taken that cycle
// - system call saves following instruction address
// - disabled aux instruction vectors to 0x0F20
// - no aux unit: aux exception never raised
// - entry copies state word into save state
// - entry clears listed state bits, keeps others
// - all noncritical; return restores primary pair
// - timeout when counter at 1 is decremented
// - from 1 counter becomes 0 or reloads
// - timeout sets flag; interrupt vectors 0x1000
// - interrupt taken cycle after flag sets
// - software clear to 0 is no timeout
// - flag persists; interrupt recurs until cleared
// - needs timer enable and external enable
// - timer interrupt saves next instruction address
// - timer entry leaves other status bits alone
// - external enable low blocks asynchronous interrupts
//
// Added by the designer: the APB interface to the registers and the address map.
module cpu_exception_entry_unit #(
    parameter bit HAS_FLOAT = 1'b1,
    parameter bit HAS_AUX = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [exc_entry_pkg::ADDR_W-1:0] paddr,
    input wire logic [exc_entry_pkg::DATA_W-1:0] pwdata,
    output logic [exc_entry_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire exc_entry_pkg::instr_s instr,
    output exc_entry_pkg::redirect_s redirect,
    output exc_entry_pkg::cause_e cause,
    output logic [exc_entry_pkg::DATA_W-1:0] machine_state_out
);
    import exc_entry_pkg::*;

    // ==========================================
    // register decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    logic [DATA_W-1:0] machine_state_word;
    logic [DATA_W-1:0] save_restore_pc;
    logic [DATA_W-1:0] save_restore_state;
    logic [DATA_W-1:0] critical_save_pc;
    logic [DATA_W-1:0] critical_save_state;
    logic [DATA_W-1:0] exception_syndrome_word;
    logic [DATA_W-1:0] data_fault_address_word;
    logic [DATA_W-1:0] interval_down_counter;
    logic [DATA_W-1:0] interval_reload;
    logic [DATA_W-1:0] timer_status_word;
    logic [DATA_W-1:0] timer_control_word;

    // one wait state: pready rises on the second access cycle
    wire access = psel & penable;
    wire done = access & pready;
    wire wr = done & pwrite;
    wire next_pready = access & ~pready;

    wire hit_state = hit(paddr, OFF_STATE);
    wire hit_spc = hit(paddr, OFF_SAVE_PC);
    wire hit_sst = hit(paddr, OFF_SAVE_STATE);
    wire hit_cpc = hit(paddr, OFF_CRIT_PC);
    wire hit_cst = hit(paddr, OFF_CRIT_STATE);
    wire hit_syn = hit(paddr, OFF_SYNDROME);
    wire hit_fa = hit(paddr, OFF_FAULT_ADDR);
    wire hit_cnt = hit(paddr, OFF_COUNTER);
    wire hit_rel = hit(paddr, OFF_RELOAD);
    wire hit_ts = hit(paddr, OFF_TSTATUS);
    wire hit_tc = hit(paddr, OFF_TCONTROL);
    wire mapped = hit_state | hit_spc | hit_sst | hit_cpc | hit_cst |
                  hit_syn | hit_fa | hit_cnt | hit_rel | hit_ts | hit_tc;

    wire [DATA_W-1:0] read_word =
        hit_state ? machine_state_word :
        hit_spc ? save_restore_pc :
        hit_sst ? save_restore_state :
        hit_cpc ? critical_save_pc :
        hit_cst ? critical_save_state :
        hit_syn ? exception_syndrome_word :
        hit_fa ? data_fault_address_word :
        hit_cnt ? interval_down_counter :
        hit_rel ? interval_reload :
        hit_ts ? timer_status_word :
        hit_tc ? timer_control_word : RESET_WORD;

    wire [DATA_W-1:0] next_prdata =
        (next_pready & ~pwrite) ? read_word : RESET_WORD;
    wire next_pslverr = next_pready & ~mapped;

    // ==========================================
    // interval timer
    wire cnt_write = wr & hit_cnt;
    wire cnt_live = interval_down_counter != RESET_WORD;
    wire cnt_at_one = interval_down_counter == COUNT_ONE;
    // a software write preempts the decrement
    wire timeout = cnt_at_one & ~cnt_write;
    wire auto_reload = timer_control_word[TC_AUTO_RELOAD];

    // zero or reload after the last tick
    wire [DATA_W-1:0] tick_value =
        cnt_at_one ? (auto_reload ? interval_reload : RESET_WORD) :
        interval_down_counter - COUNT_ONE;
    wire [DATA_W-1:0] next_counter =
        cnt_write ? pwdata :
        cnt_live ? tick_value : interval_down_counter;

    wire [DATA_W-1:0] ts_clear = (wr & hit_ts) ? pwdata : RESET_WORD;
    wire [DATA_W-1:0] ts_set = {{(DATA_W-1){1'b0}}, timeout} << TS_TIMEOUT;
    wire [DATA_W-1:0] next_tstatus =
        (timer_status_word & ~ts_clear) | ts_set;

    // ==========================================
    // exception selection
    wire ins = instr.valid;
    wire ext_en = machine_state_word[MS_EXT_EN];
    wire take_timer = timer_status_word[TS_TIMEOUT] &
                      timer_control_word[TC_IRQ_EN] & ext_en;
    // only with a float unit present
    wire take_float = ~take_timer & ins & HAS_FLOAT &
                      (instr.kind == KIND_FLOAT) &
                      ~machine_state_word[MS_FLOAT_EN];
    // only with an aux unit present
    wire take_aux = ~take_timer & ins & HAS_AUX &
                    (instr.kind == KIND_AUX) &
                    ~machine_state_word[MS_AUX_EN];
    wire take_sc = ~take_timer & ins & (instr.kind == KIND_SYSCALL);
    wire take_ret = ~take_timer & ins & (instr.kind == KIND_RETURN);
    wire entry = take_timer | take_float | take_aux | take_sc;

    wire [DATA_W-1:0] entry_pc =
        take_sc ? instr.pc + INSTR_BYTES : instr.pc;
    wire [DATA_W-1:0] entry_vec =
        take_timer ? VEC_INTERVAL :
        take_float ? VEC_FLOAT :
        take_aux ? VEC_AUX : VEC_SYSCALL;

    // entry clears, return restores primary pair
    wire [DATA_W-1:0] next_state =
        entry ? (machine_state_word & ~ENTRY_CLEAR_MASK) :
        take_ret ? save_restore_state :
        (wr & hit_state) ? pwdata : machine_state_word;
    wire [DATA_W-1:0] next_spc =
        entry ? entry_pc : (wr & hit_spc) ? pwdata : save_restore_pc;
    wire [DATA_W-1:0] next_sst =
        entry ? machine_state_word :
        (wr & hit_sst) ? pwdata : save_restore_state;

    // one driver for the whole struct, no per-member assigns
    wire [DATA_W-1:0] next_redirect_pc =
        entry ? entry_vec :
        take_ret ? save_restore_pc : RESET_WORD;
    wire redirect_s next_redirect = {entry | take_ret, next_redirect_pc};

    wire cause_e next_cause =
        take_timer ? CAUSE_INTERVAL :
        take_float ? CAUSE_FLOAT :
        take_aux ? CAUSE_AUX :
        take_sc ? CAUSE_SYSCALL :
        take_ret ? CAUSE_RETURN : CAUSE_NONE;

    // ==========================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RESET_WORD;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            machine_state_word <= RESET_WORD;
            save_restore_pc <= RESET_WORD;
            save_restore_state <= RESET_WORD;
            machine_state_out <= RESET_WORD;
        end else begin
            machine_state_word <= next_state;
            save_restore_pc <= next_spc;
            save_restore_state <= next_sst;
            machine_state_out <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            critical_save_pc <= RESET_WORD;
            critical_save_state <= RESET_WORD;
            exception_syndrome_word <= RESET_WORD;
            data_fault_address_word <= RESET_WORD;
        end else begin
            if (wr & hit_cpc) begin
                critical_save_pc <= pwdata;
            end
            if (wr & hit_cst) begin
                critical_save_state <= pwdata;
            end
            if (wr & hit_syn) begin
                exception_syndrome_word <= pwdata;
            end
            if (wr & hit_fa) begin
                data_fault_address_word <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_down_counter <= RESET_WORD;
            interval_reload <= RESET_WORD;
            timer_status_word <= RESET_WORD;
            timer_control_word <= RESET_WORD;
        end else begin
            interval_down_counter <= next_counter;
            timer_status_word <= next_tstatus;
            if (wr & hit_rel) begin
                interval_reload <= pwdata;
            end
            if (wr & hit_tc) begin
                timer_control_word <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            redirect <= '0;
            cause <= CAUSE_NONE;
        end else begin
            redirect <= next_redirect;
            cause <= next_cause;
        end
    end

endmodule : cpu_exception_entry_unit

// ==== testbench/exc_entry_props.sv ====
module exc_entry_props import exc_entry_pkg::*; #(
    parameter bit HAS_FLOAT = 1'b1,
    parameter bit HAS_AUX = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [exc_entry_pkg::ADDR_W-1:0] paddr,
    input wire logic [exc_entry_pkg::DATA_W-1:0] pwdata,
    input wire logic [exc_entry_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire exc_entry_pkg::instr_s instr,
    input wire exc_entry_pkg::redirect_s redirect,
    input wire exc_entry_pkg::cause_e cause,
    input wire logic [exc_entry_pkg::DATA_W-1:0] machine_state_out
);
    localparam logic [DATA_W-1:0] KEEP = 32'h0002_1200;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic entry;
    wire logic tmr;
    assign entry = redirect.valid && cause != CAUSE_RETURN;
    assign tmr = cause == CAUSE_INTERVAL;
    // ==========================================
    // sequences
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    // ==========================================
    // properties
    AST_APB_WAIT: assert property (s_setup |=> s_answer)
        else $error("apb wait state wrong");
    AST_SYSCALL: assert property (instr.valid && instr.kind == KIND_SYSCALL
        |=> redirect.valid && (tmr || (cause == CAUSE_SYSCALL
        && redirect.pc == VEC_SYSCALL))) else $error("syscall not taken");
    AST_FLOAT: assert property (instr.valid && instr.kind == KIND_FLOAT
        && HAS_FLOAT && !machine_state_out[MS_FLOAT_EN] |=> tmr
        || (cause == CAUSE_FLOAT && redirect.pc == VEC_FLOAT))
        else $error("float fault not taken");
    AST_AUX: assert property (instr.valid && instr.kind == KIND_AUX
        && HAS_AUX && !machine_state_out[MS_AUX_EN] |=> tmr
        || (cause == CAUSE_AUX && redirect.pc == VEC_AUX))
        else $error("aux fault not taken");
    AST_CLEAR: assert property (entry
        |-> (machine_state_out & ENTRY_CLEAR_MASK) == '0)
        else $error("state bits not cleared");
    AST_KEEP: assert property (entry |-> (machine_state_out & KEEP)
        == ($past(machine_state_out) & KEEP)) else $error("kept bits lost");
    AST_TIMER_VEC: assert property (redirect.valid && tmr
        |-> redirect.pc == VEC_INTERVAL) else $error("timer vector wrong");
    AST_EE_GATE: assert property (!machine_state_out[MS_EXT_EN]
        |=> !tmr) else $error("timer taken while disabled");
    AST_RETURN: assert property (instr.valid && instr.kind == KIND_RETURN
        |=> redirect.valid && (tmr || cause == CAUSE_RETURN))
        else $error("return not taken");
endmodule : exc_entry_props

bind cpu_exception_entry_unit exc_entry_props #(.HAS_FLOAT(HAS_FLOAT),
    .HAS_AUX(HAS_AUX)) props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
    .redirect(redirect), .cause(cause),
    .machine_state_out(machine_state_out));

// ==== testbench/cpu_exception_entry_unit_bench.sv ====
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module cpu_exception_entry_unit_bench import exc_entry_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [DATA_W-1:0] KEEP = 32'h0002_1200;
    localparam logic [DATA_W-1:0] EXT = 32'h1 << MS_EXT_EN;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata, rdv, state_out;
    logic pready, pslverr, err;
    instr_s instr_in = '0;
    redirect_s redirect, redirect_b;
    cause_e cause;
    int num_errors = 0;
    int total_checks = 0;
    int irq_count = 0;
    cpu_exception_entry_unit uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr(instr_in), .redirect(redirect),
        .cause(cause), .machine_state_out(state_out));
    // variant with neither unit fitted
    cpu_exception_entry_unit #(.HAS_FLOAT(1'b0), .HAS_AUX(1'b0)) uut_bare (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .instr(instr_in), .redirect(redirect_b),
        .cause(), .machine_state_out());
    always #25 pclk = ~pclk;
    // settled mid-cycle, so no race with the launching edge
    always @(negedge pclk) begin
        if (redirect.valid === 1'b1 && cause === CAUSE_INTERVAL) irq_count++;
    end
    // ==========================================
    // bus and stream drivers
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look mid-cycle, then release at the edge that samples pready
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) num_errors++;
        rdv = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, '0);
        `CHK(rdv, e)
    endtask : rd
    task automatic step(input instr_kind_e k, input logic [DATA_W-1:0] pc);
        @(posedge pclk);
        instr_in <= '{1'b1, k, pc};
        @(posedge pclk);
        instr_in <= '{1'b0, KIND_PLAIN, pc};
        @(negedge pclk);
    endtask : step
    // ==========================================
    // scenarios
    task automatic t_syscall;
        logic [DATA_W-1:0] s;
        s = ENTRY_CLEAR_MASK | KEEP;
        apb(1'b0, 8'h2C, '0);
        `CHK({err, rdv}, {1'b1, 32'h0})
        for (int i = 0; i < 4; i++) wr(OFF_CRIT_PC + 8'(i * 4), 32'hA5A5 + i);
        wr(OFF_STATE, s);
        step(KIND_SYSCALL, 32'h0000_2000);
        `CHK({redirect, cause}, {1'b1, VEC_SYSCALL, CAUSE_SYSCALL})
        rd(OFF_SAVE_PC, 32'h0000_2004);
        rd(OFF_SAVE_STATE, s);
        rd(OFF_STATE, s & ~ENTRY_CLEAR_MASK);
        for (int i = 0; i < 4; i++) begin
            rd(OFF_CRIT_PC + 8'(i * 4), 32'hA5A5 + i);
        end
        step(KIND_RETURN, 32'h0000_3000);
        `CHK({redirect, cause}, {1'b1, 32'h2004, CAUSE_RETURN})
        rd(OFF_STATE, s);
    endtask : t_syscall
    task automatic t_units;
        instr_kind_e k;
        cause_e c;
        int en;
        for (int i = 0; i < 2; i++) begin
            k = i ? KIND_AUX : KIND_FLOAT;
            c = i ? CAUSE_AUX : CAUSE_FLOAT;
            en = i ? MS_AUX_EN : MS_FLOAT_EN;
            wr(OFF_STATE, 32'h1 << en);
            step(k, 32'h0000_4000);
            `CHK(redirect.valid, 1'b0)
            wr(OFF_STATE, KEEP);
            step(k, 32'h0000_4000);
            `CHK({redirect, cause}, {1'b1, i ? VEC_AUX : VEC_FLOAT, c})
            `CHK(redirect_b.valid, 1'b0)
            rd(OFF_SAVE_PC, 32'h0000_4000);
            rd(OFF_STATE, KEEP);
        end
    endtask : t_units
    task automatic t_timer;
        int c;
        wr(OFF_TCONTROL, 32'h1);
        wr(OFF_STATE, EXT);
        instr_in <= '{1'b1, KIND_PLAIN, 32'h0000_5000};
        wr(OFF_COUNTER, COUNT_ONE);
        repeat (2) begin
            @(negedge pclk);
            `CHK(redirect.valid, 1'b0)
        end
        @(negedge pclk);
        `CHK({redirect, cause}, {1'b1, VEC_INTERVAL, CAUSE_INTERVAL})
        rd(OFF_SAVE_PC, 32'h0000_5000);
        rd(OFF_SAVE_STATE, EXT);
        rd(OFF_TSTATUS, 32'h1);
        rd(OFF_COUNTER, 32'h0);
        rd(OFF_STATE, 32'h0);
        step(KIND_RETURN, 32'h0000_6000);
        @(negedge pclk);
        `CHK({redirect.valid, cause}, {1'b1, CAUSE_INTERVAL})
        wr(OFF_TSTATUS, 32'h1);
        rd(OFF_TSTATUS, 32'h0);
        step(KIND_RETURN, 32'h0000_6000);
        @(negedge pclk);
        `CHK(redirect.valid, 1'b0)
        wr(OFF_COUNTER, 32'h40);
        wr(OFF_COUNTER, 32'h0);
        c = irq_count;
        repeat (80) @(posedge pclk);
        rd(OFF_TSTATUS, 32'h0);
        wr(OFF_TCONTROL, 32'h0);
        wr(OFF_COUNTER, COUNT_ONE);
        rd(OFF_TSTATUS, 32'h1);
        wr(OFF_STATE, 32'h0);
        wr(OFF_TCONTROL, 32'h1);
        repeat (4) @(posedge pclk);
        `CHK(irq_count, c)
        wr(OFF_STATE, EXT);
        repeat (4) @(posedge pclk);
        `CHK(irq_count, c + 1)
        wr(OFF_TSTATUS, 32'h1);
        wr(OFF_TCONTROL, 32'h2);
        wr(OFF_RELOAD, 32'h100);
        wr(OFF_COUNTER, COUNT_ONE);
        apb(1'b0, OFF_COUNTER, '0);
        `CHK(rdv != 0 && rdv <= 32'h100, 1'b1)
        rd(OFF_TSTATUS, 32'h1);
    endtask : t_timer
    // ==========================================
    // run control
    task automatic test_done;
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (3000) @(posedge pclk);
        num_errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_syscall();
        t_units();
        t_timer();
        test_done();
    end
endmodule : cpu_exception_entry_unit_bench
